// *** design/ulr_pkg.sv ***
package ulr_pkg;

   // ----------------------------------------------------------------
   // Receive timing, counted in device clocks
   // ----------------------------------------------------------------
   localparam int BIT_CLOCKS = 16;
   localparam int START_CHECK_HALF_PERIODS = 15;
   localparam int START_CHECK_CYCLES = START_CHECK_HALF_PERIODS / 2;
   localparam int MIN_DATA_BITS = 5;
   localparam int DATA_W = 8;

   // ----------------------------------------------------------------
   // Line format control register fields
   // ----------------------------------------------------------------
   localparam int CTL_TR = 7;
   localparam int CTL_BRK = 6;
   localparam int CTL_IE = 5;
   localparam int CTL_WL_HI = 4;
   localparam int CTL_WL_LO = 3;
   localparam int CTL_STOP = 2;
   localparam int CTL_EVEN = 1;
   localparam int CTL_POFF = 0;
   localparam logic [7:0] CTL_RESET = 8'h00;

   // ----------------------------------------------------------------
   // Status byte fields and other reset values
   // ----------------------------------------------------------------
   localparam int ST_TX_HOLDING_EMPTY = 7;
   localparam int ST_TX_SHIFTER_EMPTY = 6;
   localparam int ST_PSI = 5;
   localparam int ST_ES = 4;
   localparam int ST_FE = 3;
   localparam int ST_PE = 2;
   localparam int ST_OE = 1;
   localparam int ST_DA = 0;
   localparam logic [7:0] HOLD_RESET = 8'h00;

   // Receiver sequencer states
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_SHIFT} ulr_rx_state_t;

   // Number of data bits for a word length code
   function automatic logic [3:0] data_bits(input logic [1:0] wl);
      data_bits = 4'(MIN_DATA_BITS) + {2'h0, wl};
   endfunction

endpackage

// *** design/ulr_link_if.sv ***
`timescale 1ns/100ps
interface ulr_link_if;
   // Decoded bus events
   logic wr_ctrl;
   logic wr_data;
   logic rd_data;
   logic rd_stat;
   logic drive_en;
   logic [7:0] wdata;
   // Control register and break termination
   logic [7:0] ctrl;
   logic break_kill;

   modport dec_mp(output wr_ctrl, wr_data, rd_data, rd_stat, drive_en, wdata);
   modport ctrl_mp(input wr_ctrl, wdata, break_kill, output ctrl);
   modport core_mp(input wr_ctrl, wr_data, rd_data, rd_stat, drive_en, wdata, ctrl,
                   output break_kill);
endinterface

// *** design/ulr_bus_dec.sv ***
`timescale 1ns/100ps
module ulr_bus_dec (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic clk_en_i,
   // Processor bus pins
   input wire logic select_a_i,
   input wire logic select_b_n_i,
   input wire logic select_c_i,
   input wire logic rd_wr_i,
   input wire logic reg_select_i,
   input wire logic bus_timing_strobe_i,
   input wire logic [7:0] tx_bus_i,
   // Decoded events
   ulr_link_if.dec_mp lk
);
   logic strobe_q;
   logic wsel_q;
   logic reg_select_q;
   logic [7:0] wdata_q;
   wire sel = select_a_i & ~select_b_n_i & select_c_i;
   wire lead = bus_timing_strobe_i & ~strobe_q;
   wire trail = ~bus_timing_strobe_i & strobe_q;

   // Previous strobe level and write qualifiers held over the strobe
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         strobe_q <= 1'b0;
         wsel_q <= 1'b0;
         reg_select_q <= 1'b0;
         wdata_q <= 8'h00;
      end else if (clk_en_i) begin
         strobe_q <= bus_timing_strobe_i;
         wsel_q <= sel & ~rd_wr_i;
         reg_select_q <= reg_select_i;
         wdata_q <= tx_bus_i;
      end
   end

   // Writes act on the strobe trailing edge, reads on its leading edge
   assign lk.drive_en = sel & rd_wr_i;
   assign lk.wr_ctrl = clk_en_i & trail & wsel_q & reg_select_q;
   assign lk.wr_data = clk_en_i & trail & wsel_q & ~reg_select_q;
   assign lk.rd_data = clk_en_i & lead & sel & rd_wr_i & ~reg_select_i;
   assign lk.rd_stat = clk_en_i & lead & sel & rd_wr_i & reg_select_i;
   assign lk.wdata = wdata_q;

   a_drive_read: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      lk.drive_en |-> rd_wr_i && select_a_i && !select_b_n_i && select_c_i)
      else $error("bus driven without read selection");
endmodule

// *** design/ulr_ctrl_reg.sv ***
`timescale 1ns/100ps
module ulr_ctrl_reg (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic clk_en_i,
   // Write and control outputs
   ulr_link_if.ctrl_mp lk
);
   logic [7:0] ctrl_q;
   logic [7:0] ctrl_d;
   wire tr_write = lk.wdata[ulr_pkg::CTL_TR];

   // Request write only sets the request bit; break may be ended by hardware
   always_comb begin
      ctrl_d = ctrl_q;
      if (lk.break_kill) begin
         ctrl_d[ulr_pkg::CTL_BRK] = 1'b0;
      end
      if (lk.wr_ctrl && tr_write) begin
         ctrl_d[ulr_pkg::CTL_TR] = 1'b1;
      end else if (lk.wr_ctrl) begin
         ctrl_d = lk.wdata;
      end
   end

   // Control register
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctrl_q <= ulr_pkg::CTL_RESET;
      end else if (clk_en_i) begin
         ctrl_q <= ctrl_d;
      end
   end

   assign lk.ctrl = ctrl_q;

   a_tr_keeps_fmt: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (clk_en_i && lk.wr_ctrl && tr_write && !lk.break_kill)
      |=> (ctrl_q[6:0] == $past(ctrl_q[6:0])) && ctrl_q[ulr_pkg::CTL_TR])
      else $error("control write with request bit changed format bits");
endmodule

// *** design/ulr_rx_top.sv ***
`timescale 1ns/100ps
// Operation
// - Start bit is confirmed only if input is still low 7 clocks after edge.
// - Data, parity and stop bits are sampled every sixteen clocks at centre.
// - At first stop bit centre the shifter is copied to the holding register.
// - Unused high bits of short characters read back as zero.
// - Loading while data-available is still set raises overrun.
// - Parity and framing flags become valid one clock after the load.
// - Data-available and interrupt outputs go low at that same point.
// - Bus drivers are enabled only when selected and read/write is high.
// - A read returns data when select is low and status when high.
// - The data read strobe clears data-available.
// - Parity inhibit disables checking, holds parity fault low, ignores even.
// - Even parity control selects even when set, odd when clear.
// - Length code picks 5 to 8 bits; stop select picks 1, 1.5 or 2 stops.
// - Interrupt enable gates every interrupt source.
// - Break holds serial out low until cleared, reset, clear-to-send rise or word.
// - Transmit request drives request-to-send low and arms holding-empty interrupt.
// - A control write with transmit request set leaves other bits unchanged.
// - Device clock is sixteen times the bit rate; all timing counts it.
// - Clear resets control, status and holding registers and sets serial out high.
// - Framing fault is set when the bit after data and parity is not high.
// - Select low: write transmit data, read receive data; high: control, status.
module ulr_rx_top #(
   parameter int BIT_CLOCKS = ulr_pkg::BIT_CLOCKS,
   parameter int START_CHECK_CYCLES = ulr_pkg::START_CHECK_CYCLES
) (
   // Clock, reset and enable
   input wire logic clock_i,
   input wire logic nrst_i,
   input wire logic clk_en_i,
   // Processor bus
   input wire logic select_a_i,
   input wire logic select_b_n_i,
   input wire logic select_c_i,
   input wire logic rd_wr_i,
   input wire logic reg_select_i,
   input wire logic bus_timing_strobe_i,
   input wire logic [7:0] tx_bus_i,
   output logic [7:0] rx_bus_o,
   output logic rx_bus_oe_o,
   // Serial line
   input wire logic serial_in_i,
   output logic serial_out_o,
   // Receive status pins and interrupt
   output logic rx_char_ready_n_o,
   output logic framing_fault_flag_o,
   output logic rx_error_o,
   output logic int_n_o,
   // Transmitter path
   input wire logic tx_serial_i,
   input wire logic tx_word_done_i,
   input wire logic tx_holding_empty_i,
   input wire logic tx_shifter_empty_i,
   output logic tx_load_o,
   output logic [7:0] tx_data_o,
   output logic [7:0] line_format_o,
   // Peripheral handshake
   output logic tx_request_n_o,
   input wire logic clear_to_send_n_i,
   input wire logic peer_status_edge_n_i,
   input wire logic ext_status_n_i
);
   localparam int CW = $clog2(BIT_CLOCKS);

   // ----------------------------------------------------------------
   // Parameter checks
   // ----------------------------------------------------------------
   if (BIT_CLOCKS < 4 || START_CHECK_CYCLES < 1 || START_CHECK_CYCLES >= BIT_CLOCKS) begin : g_chk
      $error("bit timing parameters out of range");
   end

   // ----------------------------------------------------------------
   // Reset release
   // ----------------------------------------------------------------
   logic rst_s1_q;
   logic rst_n_q;

   // Async assert, release through two flops
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rst_s1_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_n_q <= rst_s1_q;
      end
   end

   // ----------------------------------------------------------------
   // Bus decode and control register
   // ----------------------------------------------------------------
   ulr_link_if lk ();

   ulr_bus_dec u_dec (
      .clock_i(clock_i),
      .rst_n_i(rst_n_q),
      .clk_en_i(clk_en_i),
      .select_a_i(select_a_i),
      .select_b_n_i(select_b_n_i),
      .select_c_i(select_c_i),
      .rd_wr_i(rd_wr_i),
      .reg_select_i(reg_select_i),
      .bus_timing_strobe_i(bus_timing_strobe_i),
      .tx_bus_i(tx_bus_i),
      .lk(lk.dec_mp)
   );

   ulr_ctrl_reg u_ctrl (
      .clock_i(clock_i),
      .rst_n_i(rst_n_q),
      .clk_en_i(clk_en_i),
      .lk(lk.ctrl_mp)
   );

   // Control fields
   wire [1:0] wl = lk.ctrl[ulr_pkg::CTL_WL_HI:ulr_pkg::CTL_WL_LO];
   wire poff = lk.ctrl[ulr_pkg::CTL_POFF];
   wire even = lk.ctrl[ulr_pkg::CTL_EVEN];
   wire ie = lk.ctrl[ulr_pkg::CTL_IE];
   wire brk = lk.ctrl[ulr_pkg::CTL_BRK];
   wire tr = lk.ctrl[ulr_pkg::CTL_TR];

   // ----------------------------------------------------------------
   // Receive sequencer
   // ----------------------------------------------------------------
   ulr_pkg::ulr_rx_state_t state_q;
   ulr_pkg::ulr_rx_state_t state_d;
   logic [CW-1:0] cnt_q;
   logic [3:0] idx_q;
   logic [7:0] shreg_q;
   logic par_q;
   logic sin_prev_q;

   // Frame shape from the length code and parity inhibit
   wire [3:0] dlen = ulr_pkg::data_bits(wl);
   wire [3:0] stop_idx = dlen + {3'h0, ~poff};
   wire fall = sin_prev_q & ~serial_in_i;
   wire chk_now = (state_q == ulr_pkg::RX_START) && (cnt_q == CW'(START_CHECK_CYCLES - 1));
   wire at_sample = (state_q == ulr_pkg::RX_SHIFT) && (cnt_q == CW'(BIT_CLOCKS - 1));
   wire stop_now = at_sample && (idx_q == stop_idx);
   wire data_now = at_sample && (idx_q < dlen);
   wire par_now = at_sample && (idx_q == dlen) && !poff;
   // Parity over data and received parity bit; odd selected when even is clear
   wire par_fault = ~poff & ((^shreg_q) ^ par_q ^ ~even);

   // Next state
   always_comb begin
      state_d = state_q;
      case (state_q)
         ulr_pkg::RX_IDLE: begin
            if (fall) begin
               state_d = ulr_pkg::RX_START;
            end
         end
         ulr_pkg::RX_START: begin
            if (chk_now && serial_in_i) begin
               state_d = ulr_pkg::RX_IDLE;
            end else if (chk_now) begin
               state_d = ulr_pkg::RX_SHIFT;
            end
         end
         ulr_pkg::RX_SHIFT: begin
            if (stop_now) begin
               state_d = ulr_pkg::RX_IDLE;
            end
         end
         default: begin
            state_d = ulr_pkg::RX_IDLE;
         end
      endcase
   end

   // State and tick counter, restarted at each phase change
   always_ff @(posedge clock_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         state_q <= ulr_pkg::RX_IDLE;
         cnt_q <= '0;
         sin_prev_q <= 1'b1;
      end else if (clk_en_i) begin
         state_q <= state_d;
         sin_prev_q <= serial_in_i;
         cnt_q <= (state_d != state_q || at_sample) ? '0 : cnt_q + 1'b1;
      end
   end

   // Shifter, cleared at start so unused high bits stay zero
   always_ff @(posedge clock_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         shreg_q <= 8'h00;
         idx_q <= 4'h0;
         par_q <= 1'b0;
      end else if (clk_en_i) begin
         if (chk_now) begin
            shreg_q <= 8'h00;
            idx_q <= 4'h0;
         end else if (at_sample) begin
            idx_q <= idx_q + 4'h1;
            if (data_now) begin
               shreg_q[idx_q[2:0]] <= serial_in_i;
            end
            if (par_now) begin
               par_q <= serial_in_i;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Holding register and receive flags
   // ----------------------------------------------------------------
   logic [7:0] hold_q;
   logic ld_q;
   logic pe_stage_q;
   logic fe_stage_q;
   logic da_q;
   logic oe_q;
   logic pe_q;
   logic fe_q;

   // Load and overrun at the stop centre; parity, framing and data-available one clock later
   always_ff @(posedge clock_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         hold_q <= ulr_pkg::HOLD_RESET;
         ld_q <= 1'b0;
         pe_stage_q <= 1'b0;
         fe_stage_q <= 1'b0;
         oe_q <= 1'b0;
         pe_q <= 1'b0;
         fe_q <= 1'b0;
      end else if (clk_en_i) begin
         ld_q <= stop_now;
         if (stop_now) begin
            hold_q <= shreg_q;
            oe_q <= da_q;
            pe_stage_q <= par_fault;
            fe_stage_q <= ~serial_in_i;
         end
         if (ld_q) begin
            pe_q <= pe_stage_q;
            fe_q <= fe_stage_q;
         end
      end
   end

   // Data available: a new character wins over a clearing read
   always_ff @(posedge clock_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         da_q <= 1'b0;
      end else if (clk_en_i) begin
         if (ld_q) begin
            da_q <= 1'b1;
         end else if (lk.rd_data) begin
            da_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Peripheral status flags
   // ----------------------------------------------------------------
   logic psi_prev_q;
   logic cts_prev_q;
   logic psi_q;
   logic cts_q;
   wire psi_fall = psi_prev_q & ~peer_status_edge_n_i;
   wire cts_rise = ~cts_prev_q & clear_to_send_n_i;
   wire tx_done = tx_holding_empty_i & tx_shifter_empty_i;

   // Edge flags cleared by a status read, set wins
   always_ff @(posedge clock_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         psi_prev_q <= 1'b1;
         cts_prev_q <= 1'b1;
         psi_q <= 1'b0;
         cts_q <= 1'b0;
      end else if (clk_en_i) begin
         psi_prev_q <= peer_status_edge_n_i;
         cts_prev_q <= clear_to_send_n_i;
         psi_q <= psi_fall | (psi_q & ~lk.rd_stat);
         cts_q <= (cts_rise & tx_done) | (cts_q & ~lk.rd_stat);
      end
   end

   // ----------------------------------------------------------------
   // Read path and interrupt
   // ----------------------------------------------------------------
   logic [7:0] rdata_q;
   wire [7:0] status = {tx_holding_empty_i, tx_shifter_empty_i, psi_q, ~ext_status_n_i,
                        fe_q, pe_q, oe_q, da_q};
   wire irq_any = da_q | (tr & tx_holding_empty_i) | tx_done | psi_q | cts_q;

   // Read mux registered toward the bus
   always_ff @(posedge clock_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         rdata_q <= 8'h00;
      end else if (clk_en_i) begin
         rdata_q <= reg_select_i ? status : hold_q;
      end
   end

   assign rx_bus_o = rdata_q;
   assign rx_bus_oe_o = lk.drive_en;
   assign rx_char_ready_n_o = ~da_q;
   assign int_n_o = ~(ie & irq_any);
   assign framing_fault_flag_o = fe_q;
   assign rx_error_o = pe_q | oe_q;

   // ----------------------------------------------------------------
   // Transmit side control
   // ----------------------------------------------------------------
   logic sout_q;
   logic [7:0] txd_q;

   // Break ends on clear-to-send rise or a transmitted word
   assign lk.break_kill = clk_en_i & (cts_rise | tx_word_done_i);

   // Serial out forced low in break, high under reset
   always_ff @(posedge clock_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         sout_q <= 1'b1;
         txd_q <= 8'h00;
      end else if (clk_en_i) begin
         sout_q <= brk ? 1'b0 : tx_serial_i;
         if (lk.wr_data) begin
            txd_q <= lk.wdata;
         end
      end
   end

   assign serial_out_o = sout_q;
   assign tx_data_o = txd_q;
   assign tx_load_o = lk.wr_data;
   assign line_format_o = lk.ctrl;
   assign tx_request_n_o = ~tr;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_start_reject: assert property (@(posedge clock_i) disable iff (!rst_n_q)
      (clk_en_i && chk_now && serial_in_i) |=> state_q == ulr_pkg::RX_IDLE)
      else $error("start edge high at check was not discarded");
   a_start_accept: assert property (@(posedge clock_i) disable iff (!rst_n_q)
      (clk_en_i && chk_now && !serial_in_i) |=> state_q == ulr_pkg::RX_SHIFT && cnt_q == '0)
      else $error("valid start bit not accepted");
   a_load_copy: assert property (@(posedge clock_i) disable iff (!rst_n_q)
      (clk_en_i && stop_now) |=> hold_q == $past(shreg_q) && ld_q)
      else $error("holding register not loaded at stop centre");
   a_zero_fill: assert property (@(posedge clock_i) disable iff (!rst_n_q)
      (ld_q && wl == 2'h0) |-> hold_q[7:5] == 3'h0)
      else $error("unused high bits not zero");
   a_overrun_set: assert property (@(posedge clock_i) disable iff (!rst_n_q)
      (clk_en_i && stop_now && da_q) |=> oe_q)
      else $error("overrun not flagged");
   a_da_after_load: assert property (@(posedge clock_i) disable iff (!rst_n_q)
      (clk_en_i && ld_q) |=> !rx_char_ready_n_o && (!ie || !int_n_o))
      else $error("data available or interrupt missing after load");
   a_da_clear: assert property (@(posedge clock_i) disable iff (!rst_n_q)
      (clk_en_i && lk.rd_data && !ld_q) |=> !da_q)
      else $error("data read did not clear data available");
   a_parity_off: assert property (@(posedge clock_i) disable iff (!rst_n_q)
      (clk_en_i && stop_now && poff) |=> ##1 !pe_q)
      else $error("parity fault with parity inhibited");
   a_irq_gate: assert property (@(posedge clock_i) disable iff (!rst_n_q)
      !ie |-> int_n_o)
      else $error("interrupt raised while disabled");
   a_break_low: assert property (@(posedge clock_i) disable iff (!rst_n_q)
      (clk_en_i && brk) |=> !serial_out_o)
      else $error("serial out not low in break");
   a_rts_req: assert property (@(posedge clock_i) disable iff (!rst_n_q)
      tr |-> !tx_request_n_o)
      else $error("request to send high with request bit set");
endmodule

// *** verif/ulr_serial_peer.sv ***
`timescale 1ns/100ps
module ulr_serial_peer (
   // Clock
   input wire logic clock_i,
   // Serial line towards the receiver
   output logic line_o
);
   // --------------------------------
   // Frame generator
   // --------------------------------
   initial line_o = 1'b1;

   // One bit cell lasts sixteen device clocks
   task automatic bit_out(input logic b);
      @(posedge clock_i) #1;
      line_o = b;
      repeat (15) @(posedge clock_i);
   endtask

   // Start, data LSB first, optional parity, one stop, then idle high
   task automatic send(input logic [7:0] d, input int n, input logic pen, par, stp);
      bit_out(1'b0);
      for (int i = 0; i < n; i++) begin
         bit_out(d[i]);
      end
      if (pen) begin
         bit_out(par);
      end
      bit_out(stp);
      @(posedge clock_i) #1;
      line_o = 1'b1;
   endtask

   // Short low pulse that must not pass as a start bit
   task automatic glitch();
      @(posedge clock_i) #1;
      line_o = 1'b0;
      repeat (3) @(posedge clock_i);
      #1;
      line_o = 1'b1;
   endtask
endmodule

// *** verif/test_uart_receiver_and_line_control.sv ***
`timescale 1ns/100ps
module test_uart_receiver_and_line_control;
   // --------------------------------
   // Signals
   // --------------------------------
   logic clock_i = 0, nrst_i = 0, sa = 0, sbn = 1, sc = 0, rw = 0, rs = 0, stb = 0;
   logic [7:0] tx_bus = 8'h00, rx_bus, cfg, d, dm, q, tx_data;
   logic oe, sout, da_n, ff, rx_err, int_n, rts_n, done = 0, cts_n = 0, es_n = 0, line;
   logic tx_load, wrs = 1;
   int err_count = 0, cmp_count = 0, cyc = 0;

   always #10 clock_i = ~clock_i;

   // Device and serial peer
   ulr_rx_top ulr_rx_top_inst (.clock_i(clock_i), .nrst_i(nrst_i), .clk_en_i(1'b1),
      .select_a_i(sa), .select_b_n_i(sbn), .select_c_i(sc), .rd_wr_i(rw),
      .reg_select_i(rs), .bus_timing_strobe_i(stb), .tx_bus_i(tx_bus), .rx_bus_o(rx_bus),
      .rx_bus_oe_o(oe), .serial_in_i(line), .serial_out_o(sout), .rx_char_ready_n_o(da_n),
      .framing_fault_flag_o(ff), .rx_error_o(rx_err), .int_n_o(int_n), .tx_serial_i(1'b1),
      .tx_word_done_i(done), .tx_holding_empty_i(1'b0), .tx_shifter_empty_i(1'b0),
      .tx_load_o(tx_load), .tx_data_o(tx_data), .line_format_o(cfg), .tx_request_n_o(rts_n),
      .clear_to_send_n_i(cts_n), .peer_status_edge_n_i(1'b1), .ext_status_n_i(es_n));
   ulr_serial_peer ulr_serial_peer_inst (.clock_i(clock_i), .line_o(line));

   // --------------------------------
   // Checking and bus tasks
   // --------------------------------
   task automatic tally_and_finish();
      if (err_count == 0 && cmp_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] g, e);
      cmp_count++;
      if (g !== e) begin
         err_count++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   // Write: strobe high one cycle, value lands on the first edge after it falls
   task automatic wr(input logic [7:0] v);
      @(posedge clock_i) #1;
      {sa, sbn, sc, rw, rs, tx_bus, stb} = {4'b1010, wrs, v, 1'b1};
      @(posedge clock_i) #1;
      stb = 0;
      #1;
      chk(tx_load, !wrs);
      repeat (2) @(posedge clock_i);
      #1;
      sa = 0;
   endtask

   // Read: data is registered one edge after select, strobe then clears
   task automatic rd(input logic r, output logic [7:0] v);
      @(posedge clock_i) #1;
      {sa, sbn, sc, rw, rs} = {4'b1011, r};
      @(posedge clock_i) #1;
      chk(oe, 1);
      v = rx_bus;
      stb = 1;
      @(posedge clock_i) #1;
      stb = 0;
      @(posedge clock_i) #1;
      {sa, rw} = 2'b00;
   endtask

   // Hang guard
   always @(posedge clock_i) begin
      cyc++;
      if (cyc == 12000) begin
         err_count++;
         tally_and_finish();
      end
   end

   // --------------------------------
   // Main sequence
   // --------------------------------
   initial begin
      repeat (10) @(posedge clock_i);
      #1;
      nrst_i = 1;
      repeat (4) @(posedge clock_i);
      #1;
      chk(cfg, 8'h00);
      chk({sout, da_n, int_n}, 3'h7);
      for (int wl = 0; wl < 4; wl++) begin
         es_n = wl[0];
         wr(8'h20 | 8'(wl << 3) | {6'h0, wl[0], 1'b0});
         chk(cfg, 8'h20 | 8'(wl << 3) | {6'h0, wl[0], 1'b0});
         d = 8'hD6 ^ 8'(wl);
         dm = d & (8'hFF >> (3 - wl));
         ulr_serial_peer_inst.send(d, 5 + wl, 1, ^dm ^ ~cfg[1], 1);
         chk({int_n, rx_err, ff}, 3'h0);
         rd(1, q);
         chk(q, {3'h0, ~wl[0], 4'h1});
         rd(0, q);
         chk(q, dm);
         chk(da_n, 1);
      end
      wr(8'h1A);
      ulr_serial_peer_inst.send(8'h3C, 8, 1, 1, 1);
      chk({rx_err, int_n, ff}, 3'h6);
      rd(0, q);
      chk(q, 8'h3C);
      ulr_serial_peer_inst.send(8'h3C, 8, 1, 0, 0);
      chk(ff, 1);
      rd(0, q);
      wr(8'h19);
      ulr_serial_peer_inst.send(8'h81, 8, 0, 0, 1);
      ulr_serial_peer_inst.send(8'h7E, 8, 0, 0, 1);
      chk({rx_err, ff}, 2'h2);
      rd(0, q);
      chk(q, 8'h7E);
      ulr_serial_peer_inst.send(8'h01, 8, 0, 0, 1);
      chk(rx_err, 0);
      rd(0, q);
      ulr_serial_peer_inst.glitch();
      repeat (200) @(posedge clock_i);
      #1;
      chk(da_n, 1);
      wr(8'h80);
      chk({cfg, rts_n}, 9'h132);
      {sa, sbn, sc, rw} = 4'b1111;
      #1;
      chk(oe, 0);
      wr(8'h40);
      chk(sout, 0);
      // Word sent during break ends it; its content is not trusted
      done = 1;
      @(posedge clock_i) #1;
      done = 0;
      repeat (2) @(posedge clock_i);
      #1;
      chk(sout, 1);
      wr(8'h40);
      chk(sout, 0);
      cts_n = 1;
      repeat (3) @(posedge clock_i);
      #1;
      chk(sout, 1);
      // Transmit data write leaves control untouched
      wrs = 0;
      wr(8'hA5);
      chk(tx_data, 8'hA5);
      chk(cfg, 8'h00);
      tally_and_finish();
   end
endmodule
